// ===== front_bus_arbitration_control_sva.sv
// Checker for the wired arbitration lines between both agent ends.
// Assumes both ends share i_clk and the asynchronous active-low reset.
`timescale 1ns/1ps
module front_bus_arbitration_control_sva (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic dev_bus_init_oe,
  input wire logic pa_bus_init_oe,
  input wire logic dev_block_next_req_oe,
  input wire logic pa_block_next_req_oe,
  input wire logic dev_symmetric_req0_oe,
  input wire logic [fsb_arb_pkg::BR_W-1:0] pa_symmetric_bus_req_oe,
  input wire logic [fsb_arb_pkg::BPM_W-1:0] dev_break_perf_mon_oe,
  input wire logic [fsb_arb_pkg::FSEL_W-1:0] clock_freq_select
);
  import fsb_arb_pkg::*;
  logic phase;
  logic next_phase;

  // Stall phase: drive edges alternate with sample edges
  always_comb begin
    next_phase = ~phase;
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase <= 1'b0;
    end else begin
      phase <= next_phase;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // Bus init drive lasts two cycles then drops
  sequence bus_init_n_pulse(logic oe);
    oe ##1 !oe;
  endsequence

  // Request strap stands for two edges after release, then lets go
  sequence strap_hold;
    (pa_symmetric_bus_req_oe != 2'h0) ##1 (pa_symmetric_bus_req_oe != 2'h0) ##1
      (pa_symmetric_bus_req_oe == 2'h0);
  endsequence

  a_bus_init_n_dev_len: assert property (
    $rose(dev_bus_init_oe) |=> bus_init_n_pulse(dev_bus_init_oe))
    else $error("processor bus init drive length wrong");
  a_bus_init_n_pa_len: assert property ($rose(pa_bus_init_oe) |=> bus_init_n_pulse(pa_bus_init_oe))
    else $error("priority bus init drive length wrong");
  a_bus_init_n_pa_gap: assert property ($fell(pa_bus_init_oe) |-> $past(pa_bus_init_oe, 2))
    else $error("priority bus init drive too short");
  a_stall_dev_edge: assert property (!$stable(dev_block_next_req_oe) |-> phase)
    else $error("processor stall drive on a sample edge");
  a_stall_pa_edge: assert property (!$stable(pa_block_next_req_oe) |-> phase)
    else $error("priority stall drive on a sample edge");
  a_strap_release: assert property (
    $rose(i_arst_n) |-> strap_hold)
    else $error("request strap not held then released");
  a_reset_quiet: assert property (
    $rose(i_arst_n) |-> !dev_symmetric_req0_oe && (clock_freq_select == FSEL_DEFAULT))
    else $error("processor request or select active at release");
  a_probe_req_in: assert property (!dev_break_perf_mon_oe[PROBE_REQ_BIT])
    else $error("processor drives probe request line");
endmodule : front_bus_arbitration_control_sva

// ===== fsb_arb_if.sv
// Wired bus lines joining the processor agent and the priority agent.
// Open-drain lines resolve low when any end enables its driver.
`timescale 1ns/1ps
interface fsb_arb_if;
  import fsb_arb_pkg::*;
  logic dev_bus_init_oe;
  logic pa_bus_init_oe;
  logic dev_block_next_req_oe;
  logic pa_block_next_req_oe;
  logic pa_priority_bus_req_oe;
  logic dev_symmetric_req0_oe;
  logic [BR_W-1:0] pa_symmetric_bus_req_oe;
  logic [BPM_W-1:0] dev_break_perf_mon_oe;
  logic pa_probe_request_oe;
  logic [FSEL_W-1:0] clock_freq_select;
  logic bus_init_n;
  logic block_next_req_n;
  logic priority_bus_req_n;
  logic [BR_W-1:0] symmetric_bus_req_n;
  logic [BPM_W-1:0] break_perf_mon_n;

  // Wire resolution of the shared lines
  assign bus_init_n = ~(dev_bus_init_oe | pa_bus_init_oe);
  assign block_next_req_n = ~(dev_block_next_req_oe | pa_block_next_req_oe);
  assign priority_bus_req_n = ~pa_priority_bus_req_oe;
  assign symmetric_bus_req_n = ~(pa_symmetric_bus_req_oe |
                                 {{(BR_W-1){1'b0}}, dev_symmetric_req0_oe});
  assign break_perf_mon_n = ~(dev_break_perf_mon_oe |
                              {pa_probe_request_oe, {(BPM_W-1){1'b0}}});

  modport processor (
    output dev_bus_init_oe, dev_block_next_req_oe, dev_symmetric_req0_oe,
    output dev_break_perf_mon_oe, clock_freq_select,
    input bus_init_n, block_next_req_n, priority_bus_req_n, symmetric_bus_req_n,
    input break_perf_mon_n
  );
  modport priority_agent (
    output pa_bus_init_oe, pa_block_next_req_oe, pa_priority_bus_req_oe,
    output pa_symmetric_bus_req_oe, pa_probe_request_oe,
    input bus_init_n, block_next_req_n, priority_bus_req_n, symmetric_bus_req_n,
    input break_perf_mon_n, clock_freq_select
  );
endinterface : fsb_arb_if

// ===== fsb_arb_pkg.sv
// Shared constants and types for the front bus arbitration ends.
// Assumes both ends run on the one common bus clock.
package fsb_arb_pkg;
  localparam int BR_W = 2;          // Symmetric request lines
  localparam int BPM_W = 6;         // Breakpoint monitor lines
  localparam int BP_STAT_W = 4;     // Plain breakpoint status lines
  localparam int PROBE_READY_BIT = 4;
  localparam int PROBE_REQ_BIT = 5;
  localparam int FSEL_W = 3;        // Clock frequency select code
  localparam int CNT_W = 4;         // Queue occupancy counters
  localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [2:0] BUS_INIT_N_PULSE_CYC = 3'h2;  // Bus init drive length
  localparam logic [2:0] STRAP_HOLD_CYC = 3'h2;   // Request strap hold after reset
  localparam logic [2:0] CYC_ZERO = 3'h0;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic REQ0_IDX = 1'b0;
  localparam logic REQ1_IDX = 1'b1;
  localparam logic [FSEL_W-1:0] FSEL_DEFAULT = 3'h0;

  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_REQ = 2'b01,
    ARB_OWN = 2'b10
  } arb_state_t;
endpackage : fsb_arb_pkg

// ===== fsb_priority_agent.sv
// Priority agent end: request line strap, priority bus request, stall,
// bus init drive and handling, probe request and frequency check.
// Assumes the processor agent shares i_clk and reset.
`timescale 1ns/1ps
module fsb_priority_agent #(
  parameter logic STRAP_LINE = 1'b0  // Request line asserted through reset
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  fsb_arb_if.priority_agent bus,
  input wire logic i_bus_init_n_drive_en,
  input wire logic i_bus_init_n_observe_en,
  input wire logic i_fatal_err,
  input wire logic i_cannot_accept,
  input wire logic i_req_push,
  input wire logic i_req_done,
  input wire logic i_probe_request,
  input wire logic [fsb_arb_pkg::FSEL_W-1:0] i_expected_freq,
  output logic o_req_issue,
  output logic o_stall_seen,
  output logic o_bus_init_n_error,
  output logic o_freq_mismatch,
  output logic o_probe_ready
);
  import fsb_arb_pkg::*;

  logic [2:0] strap_cnt;
  logic [2:0] next_strap_cnt;
  logic phase;
  logic bnr_oe;
  logic next_bnr_oe;
  logic stall_seen;
  logic next_stall_seen;
  logic [2:0] bus_init_n_cnt;
  logic [2:0] next_bus_init_n_cnt;
  logic bus_init_n_error;
  logic next_bus_init_n_error;
  logic [CNT_W-1:0] open_cnt;
  logic [CNT_W-1:0] next_open_cnt;
  logic [CNT_W-1:0] issued_cnt;
  logic [CNT_W-1:0] next_issued_cnt;
  logic priority_bus_req_n_oe;
  logic next_priority_bus_req_n_oe;
  logic req_issue;
  logic next_req_issue;
  logic freq_mismatch;
  logic probe_oe;
  logic probe_ready;
  logic issue_now;

  // Issue own work only while holding priority and no stall seen
  assign issue_now = priority_bus_req_n_oe & ~stall_seen & (issued_cnt != open_cnt);  // [R7]

  always_comb begin
    next_strap_cnt = (strap_cnt != CYC_ZERO) ? strap_cnt - CYC_ONE : strap_cnt;
    next_bnr_oe = phase ? bnr_oe : i_cannot_accept;  // [R6] [R8]
    next_stall_seen = phase ? ~bus.block_next_req_n : stall_seen;  // [R8]
    next_bus_init_n_cnt = bus_init_n_cnt;
    if (bus_init_n_cnt != CYC_ZERO) begin
      next_bus_init_n_cnt = bus_init_n_cnt - CYC_ONE;
    end else if (i_bus_init_n_drive_en && i_fatal_err) begin
      next_bus_init_n_cnt = BUS_INIT_N_PULSE_CYC;  // [R1]
    end
    // Unobserved bus init is latched for the system error policy
    next_bus_init_n_error = bus_init_n_error |
                       (~i_bus_init_n_observe_en & ~bus.bus_init_n);  // [R5]
    next_open_cnt = open_cnt;
    next_issued_cnt = issued_cnt;
    if (i_req_push && !i_req_done && open_cnt != CNT_MAX) begin
      next_open_cnt = open_cnt + CNT_ONE;
    end else if (!i_req_push && i_req_done && open_cnt != CNT_ZERO) begin
      next_open_cnt = open_cnt - CNT_ONE;
    end
    if (issue_now && !i_req_done) begin
      next_issued_cnt = issued_cnt + CNT_ONE;
    end else if (!issue_now && i_req_done && issued_cnt != CNT_ZERO) begin
      next_issued_cnt = issued_cnt - CNT_ONE;
    end
    // Hold priority until every own request has completed
    next_priority_bus_req_n_oe = (next_open_cnt != CNT_ZERO);  // [R10]
    next_req_issue = issue_now;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_cnt <= STRAP_HOLD_CYC;
      phase <= 1'b0;
      bnr_oe <= 1'b0;
      stall_seen <= 1'b0;
      bus_init_n_cnt <= CYC_ZERO;
      bus_init_n_error <= 1'b0;
      open_cnt <= CNT_ZERO;
      issued_cnt <= CNT_ZERO;
      priority_bus_req_n_oe <= 1'b0;
      req_issue <= 1'b0;
      freq_mismatch <= 1'b0;
      probe_oe <= 1'b0;
      probe_ready <= 1'b0;
    end else begin
      strap_cnt <= next_strap_cnt;
      phase <= ~phase;
      bnr_oe <= next_bnr_oe;
      stall_seen <= next_stall_seen;
      bus_init_n_cnt <= next_bus_init_n_cnt;
      bus_init_n_error <= next_bus_init_n_error;
      open_cnt <= next_open_cnt;
      issued_cnt <= next_issued_cnt;
      priority_bus_req_n_oe <= next_priority_bus_req_n_oe;
      req_issue <= next_req_issue;
      freq_mismatch <= (bus.clock_freq_select != i_expected_freq);  // [R16]
      probe_oe <= i_probe_request;  // [R15]
      probe_ready <= ~bus.break_perf_mon_n[PROBE_READY_BIT];
    end
  end

  // Strap holds one request line through reset and two edges after it
  assign bus.pa_symmetric_bus_req_oe[REQ0_IDX] = (strap_cnt != CYC_ZERO) &
                                                 (STRAP_LINE == REQ0_IDX);  // [R11]
  assign bus.pa_symmetric_bus_req_oe[REQ1_IDX] = (strap_cnt != CYC_ZERO) &
                                                 (STRAP_LINE == REQ1_IDX);  // [R11]
  assign bus.pa_bus_init_oe = (bus_init_n_cnt != CYC_ZERO);
  assign bus.pa_block_next_req_oe = bnr_oe;
  assign bus.pa_priority_bus_req_oe = priority_bus_req_n_oe;
  assign bus.pa_probe_request_oe = probe_oe;
  assign o_req_issue = req_issue;
  assign o_stall_seen = stall_seen;
  assign o_bus_init_n_error = bus_init_n_error;
  assign o_freq_mismatch = freq_mismatch;
  assign o_probe_ready = probe_ready;
endmodule : fsb_priority_agent

// ===== fsb_processor_agent.sv
// Processor end of front bus arbitration: bus init, stall, priority
// yield, symmetric request and agent ID capture, debug and clock select.
// Assumes the priority agent shares i_clk and straps the request lines
// through reset release; all bus lines are same-clock logic.
`timescale 1ns/1ps
// Contract
// R1: Drive bus init on fatal error if enabled
// R2: Observed bus init resets lock, arbitration
// R3: Bus init keeps queue counters intact
// R4: After bus init, re-arbitrate, finish pending
// R5: Priority agent handles unobserved bus init
// R6: Unable to accept, assert block next request
// R7: No new issue during stall
// R8: Stall line driven, sampled on fixed edges
// R9: Priority request blocks non-locked issue
// R10: Priority agent holds request until done
// R11: Sample request lines at reset release
// R12: Request bus on request line zero
// R13: Monitor lines show breakpoint, counter status
// R14: Monitor line four signals probe ready
// R15: Monitor line five carries probe request
// R16: Drive common clock frequency select code
// R17: Agent ID is strapped index, fixed
module fsb_processor_agent (
  input wire logic i_clk,
  input wire logic i_arst_n,
  fsb_arb_if.processor bus,
  input wire logic i_bus_init_n_drive_en,
  input wire logic i_bus_init_n_observe_en,
  input wire logic i_fatal_err,
  input wire logic i_cannot_accept,
  input wire logic i_req_push,
  input wire logic i_req_locked,
  input wire logic i_lock_end,
  input wire logic i_txn_done,
  input wire logic [fsb_arb_pkg::BP_STAT_W-1:0] i_bp_status,
  input wire logic i_probe_ready,
  input wire logic [fsb_arb_pkg::FSEL_W-1:0] i_freq_code,
  output logic o_req_issue,
  output logic o_agent_id,
  output logic o_id_valid,
  output logic o_stall_seen,
  output logic o_bus_init_n_seen,
  output logic o_lock_active,
  output logic o_probe_request,
  output logic [fsb_arb_pkg::CNT_W-1:0] o_pending_cnt,
  output logic [fsb_arb_pkg::CNT_W-1:0] o_ioq_cnt
);
  import fsb_arb_pkg::*;

  arb_state_t state;
  arb_state_t next_state;
  logic phase;
  logic next_phase;
  logic id_valid;
  logic next_id_valid;
  logic agent_id;
  logic next_agent_id;
  logic [2:0] bus_init_n_cnt;
  logic [2:0] next_bus_init_n_cnt;
  logic bus_init_n_seen;
  logic next_bus_init_n_seen;
  logic stall_seen;
  logic next_stall_seen;
  logic bnr_oe;
  logic next_bnr_oe;
  logic lock_active;
  logic next_lock_active;
  logic req_issue;
  logic next_req_issue;
  logic [CNT_W-1:0] pending_cnt;
  logic [CNT_W-1:0] next_pending_cnt;
  logic [CNT_W-1:0] ioq_cnt;
  logic [CNT_W-1:0] next_ioq_cnt;
  logic [BPM_W-1:0] bpm_oe;
  logic [BPM_W-1:0] next_bpm_oe;
  logic probe_req;
  logic next_probe_req;
  logic [FSEL_W-1:0] fsel;
  logic bus_init_n_hit;
  logic prio_seen;
  logic other_req_seen;
  logic may_issue;
  logic issue_now;

  // Bus init observed, priority request and rival symmetric request
  assign bus_init_n_hit = i_bus_init_n_observe_en & ~bus.bus_init_n & id_valid;
  assign prio_seen = ~bus.priority_bus_req_n;
  assign other_req_seen = ~bus.symmetric_bus_req_n[REQ1_IDX];
  // Issue allowed only with no stall and, under priority, only locked work
  assign may_issue = ~stall_seen & (~prio_seen | lock_active);  // [R7] [R9]
  assign issue_now = (state == ARB_OWN) & may_issue & (pending_cnt != CNT_ZERO) &
                     ~bus_init_n_hit;

  // Next values: ID capture, phase, bus init drive, stall line
  always_comb begin
    next_phase = ~phase;
    next_id_valid = 1'b1;
    next_agent_id = agent_id;
    if (!id_valid) begin
      // First edge after reset release samples the strapped line
      next_agent_id = ~bus.symmetric_bus_req_n[REQ1_IDX];  // [R11] [R17]
    end
    next_bus_init_n_cnt = bus_init_n_cnt;
    if (bus_init_n_cnt != CYC_ZERO) begin
      next_bus_init_n_cnt = bus_init_n_cnt - CYC_ONE;
    end else if (i_bus_init_n_drive_en && i_fatal_err && id_valid) begin
      next_bus_init_n_cnt = BUS_INIT_N_PULSE_CYC;  // [R1]
    end
    next_bus_init_n_seen = bus_init_n_hit;
    // Drive the stall line only on even phase, sample only on odd
    next_bnr_oe = bnr_oe;
    next_stall_seen = stall_seen;
    if (!phase) begin
      next_bnr_oe = i_cannot_accept;  // [R6] [R8]
    end else begin
      next_stall_seen = ~bus.block_next_req_n;  // [R8]
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase <= 1'b0;
      id_valid <= 1'b0;
      agent_id <= 1'b0;
      bus_init_n_cnt <= CYC_ZERO;
      bus_init_n_seen <= 1'b0;
      bnr_oe <= 1'b0;
      stall_seen <= 1'b0;
    end else begin
      phase <= next_phase;
      id_valid <= next_id_valid;
      agent_id <= next_agent_id;
      bus_init_n_cnt <= next_bus_init_n_cnt;
      bus_init_n_seen <= next_bus_init_n_seen;
      bnr_oe <= next_bnr_oe;
      stall_seen <= next_stall_seen;
    end
  end

  // Next values: arbitration state and lock tracking
  always_comb begin
    next_state = state;
    next_lock_active = lock_active;
    next_req_issue = issue_now;
    if (issue_now && i_req_locked) begin
      next_lock_active = 1'b1;
    end else if (i_lock_end) begin
      next_lock_active = 1'b0;
    end
    case (state)
      ARB_IDLE: begin
        if (id_valid && pending_cnt != CNT_ZERO) begin
          next_state = ARB_REQ;
        end
      end
      ARB_REQ: begin
        // Lower agent ID wins when both symmetric lines are active
        if (!agent_id || !other_req_seen) begin
          next_state = ARB_OWN;
        end
      end
      ARB_OWN: begin
        if (pending_cnt == CNT_ZERO ||
            (pending_cnt == CNT_ONE && issue_now)) begin
          next_state = ARB_IDLE;
        end
      end
      default: begin
        next_state = ARB_IDLE;
      end
    endcase
    if (bus_init_n_hit) begin
      // Lock and arbitration restart; re-request follows from pending work
      next_state = ARB_IDLE;  // [R2] [R4]
      next_lock_active = 1'b0;  // [R2]
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= ARB_IDLE;
      lock_active <= 1'b0;
      req_issue <= 1'b0;
    end else begin
      state <= next_state;
      lock_active <= next_lock_active;
      req_issue <= next_req_issue;
    end
  end

  // Next values: bus queue and in-order queue, untouched by bus init
  always_comb begin
    next_pending_cnt = pending_cnt;  // [R3]
    next_ioq_cnt = ioq_cnt;  // [R3]
    if (i_req_push && !issue_now && pending_cnt != CNT_MAX) begin
      next_pending_cnt = pending_cnt + CNT_ONE;
    end else if (!i_req_push && issue_now) begin
      next_pending_cnt = pending_cnt - CNT_ONE;
    end
    if (issue_now && !i_txn_done && ioq_cnt != CNT_MAX) begin
      next_ioq_cnt = ioq_cnt + CNT_ONE;
    end else if (!issue_now && i_txn_done && ioq_cnt != CNT_ZERO) begin
      next_ioq_cnt = ioq_cnt - CNT_ONE;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pending_cnt <= CNT_ZERO;
      ioq_cnt <= CNT_ZERO;
    end else begin
      pending_cnt <= next_pending_cnt;
      ioq_cnt <= next_ioq_cnt;
    end
  end

  // Next values: monitor lines, probe request and frequency code
  always_comb begin
    next_bpm_oe = '0;
    next_bpm_oe[BP_STAT_W-1:0] = i_bp_status;  // [R13]
    next_bpm_oe[PROBE_READY_BIT] = i_probe_ready;  // [R14]
    next_probe_req = ~bus.break_perf_mon_n[PROBE_REQ_BIT];  // [R15]
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bpm_oe <= '0;
      probe_req <= 1'b0;
      fsel <= FSEL_DEFAULT;
    end else begin
      bpm_oe <= next_bpm_oe;
      probe_req <= next_probe_req;
      fsel <= i_freq_code;  // [R16]
    end
  end

  // Bus drivers; request line zero is this agent's bus request
  assign bus.dev_bus_init_oe = (bus_init_n_cnt != CYC_ZERO);  // [R1]
  assign bus.dev_block_next_req_oe = bnr_oe;
  assign bus.dev_symmetric_req0_oe = (state != ARB_IDLE);  // [R12]
  assign bus.dev_break_perf_mon_oe = bpm_oe;
  assign bus.clock_freq_select = fsel;

  // User-side status
  assign o_req_issue = req_issue;
  assign o_agent_id = agent_id;
  assign o_id_valid = id_valid;
  assign o_stall_seen = stall_seen;
  assign o_bus_init_n_seen = bus_init_n_seen;
  assign o_lock_active = lock_active;
  assign o_probe_request = probe_req;
  assign o_pending_cnt = pending_cnt;
  assign o_ioq_cnt = ioq_cnt;
endmodule : fsb_processor_agent

// ===== tb_front_bus_arbitration_control.sv
// Self-checking bench joining the processor and priority ends over one interface.
// Assumes a 100 MHz bus clock and both ends released from reset together.
`timescale 1ns/1ps
module tb_front_bus_arbitration_control;
  import fsb_arb_pkg::*;
  localparam logic [6:0] DEV_PUSH = 7'h01;
  localparam logic [6:0] DEV_FATAL = 7'h02;
  localparam logic [6:0] LOCK_END = 7'h04;
  localparam logic [6:0] TXN_DONE = 7'h08;
  localparam logic [6:0] PA_PUSH = 7'h10;
  localparam logic [6:0] PA_DONE = 7'h20;
  localparam logic [6:0] PA_FATAL = 7'h40;
  logic i_clk, i_arst_n, drive_en, dev_obs_en, pa_obs_en;
  logic dev_fatal, pa_fatal, dev_cannot, pa_cannot, dev_push, dev_locked;
  logic lock_end, txn_done, pa_push, pa_done, probe_ready, probe_request;
  logic [BP_STAT_W-1:0] bp_status;
  logic [FSEL_W-1:0] freq_code, expected_freq;
  logic issue, agent_id, id_valid, stall_seen, bus_init_n_seen, lock_act, probe_request_n_seen;
  logic pa_stall, bus_init_n_err, freq_mis, probe_ready_n_seen, pa_issue;
  logic [BPM_W-1:0] bpm_exp;
  logic [CNT_W-1:0] pend, in_order_queue;
  logic req0_seen = 1'b0;
  int fail_count = 0;
  int checked = 0;
  int issues = 0;
  int bus_init_n_hits = 0;
  int pa_issues = 0;

  fsb_arb_if fsb ();
  fsb_processor_agent i_fsb_processor_agent (.i_clk(i_clk), .i_arst_n(i_arst_n), .bus(fsb),
    .i_bus_init_n_drive_en(drive_en), .i_bus_init_n_observe_en(dev_obs_en), .i_fatal_err(dev_fatal),
    .i_cannot_accept(dev_cannot), .i_req_push(dev_push), .i_req_locked(dev_locked),
    .i_lock_end(lock_end), .i_txn_done(txn_done), .i_bp_status(bp_status),
    .i_probe_ready(probe_ready), .i_freq_code(freq_code), .o_req_issue(issue),
    .o_agent_id(agent_id), .o_id_valid(id_valid), .o_stall_seen(stall_seen),
    .o_bus_init_n_seen(bus_init_n_seen), .o_lock_active(lock_act), .o_probe_request(probe_request_n_seen),
    .o_pending_cnt(pend), .o_ioq_cnt(in_order_queue));
  fsb_priority_agent #(.STRAP_LINE(1'b0)) i_fsb_priority_agent (.i_clk(i_clk),
    .i_arst_n(i_arst_n), .bus(fsb), .i_bus_init_n_drive_en(drive_en),
    .i_bus_init_n_observe_en(pa_obs_en), .i_fatal_err(pa_fatal), .i_cannot_accept(pa_cannot),
    .i_req_push(pa_push), .i_req_done(pa_done), .i_probe_request(probe_request),
    .i_expected_freq(expected_freq), .o_req_issue(pa_issue), .o_stall_seen(pa_stall),
    .o_bus_init_n_error(bus_init_n_err), .o_freq_mismatch(freq_mis), .o_probe_ready(probe_ready_n_seen));
  front_bus_arbitration_control_sva chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .dev_bus_init_oe(fsb.dev_bus_init_oe), .pa_bus_init_oe(fsb.pa_bus_init_oe),
    .dev_block_next_req_oe(fsb.dev_block_next_req_oe),
    .pa_block_next_req_oe(fsb.pa_block_next_req_oe),
    .dev_symmetric_req0_oe(fsb.dev_symmetric_req0_oe),
    .pa_symmetric_bus_req_oe(fsb.pa_symmetric_bus_req_oe),
    .dev_break_perf_mon_oe(fsb.dev_break_perf_mon_oe),
    .clock_freq_select(fsb.clock_freq_select));

  // Bus clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Event counters for issues, observed bus init and request line zero
  always @(posedge i_clk) begin
    if (issue === 1'b1) issues <= issues + 1;
    if (bus_init_n_seen === 1'b1) bus_init_n_hits <= bus_init_n_hits + 1;
    if (fsb.dev_symmetric_req0_oe === 1'b1) req0_seen <= 1'b1;
    if (pa_issue === 1'b1) pa_issues <= pa_issues + 1;
  end

  // Monitor line levels expected for given status inputs
  function automatic logic [BPM_W-1:0] bpm_expect(input logic [BP_STAT_W-1:0] bp,
                                                  input logic rdy, input logic req);
    return ~{req, rdy, bp};
  endfunction : bpm_expect

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc

  // One-cycle pulse on the selected event inputs
  task automatic pulse(input logic [6:0] sel);
    @(posedge i_clk);
    {pa_fatal, pa_done, pa_push, txn_done, lock_end, dev_fatal, dev_push} <= sel;
    @(posedge i_clk);
    {pa_fatal, pa_done, pa_push, txn_done, lock_end, dev_fatal, dev_push} <= 7'h00;
    @(negedge i_clk);
  endtask : pulse

  task automatic wait_issues(input int target, input int lim);
    int n;
    n = 0;
    while (issues < target && n < lim) begin
      @(negedge i_clk);
      n++;
    end
  endtask : wait_issues

  task automatic conclude();
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // Watchdog well beyond the expected run length
  initial begin
    #20us;
    fail_count++;
    conclude();
  end

  initial begin
    {i_arst_n, dev_fatal, pa_fatal, dev_cannot, pa_cannot, dev_push, dev_locked} = 7'h00;
    {lock_end, txn_done, pa_push, pa_done, probe_ready, probe_request} = 6'h00;
    {drive_en, dev_obs_en, pa_obs_en} = 3'h6;
    bp_status = 4'h0;
    freq_code = 3'h0;
    expected_freq = 3'h0;
    void'($urandom(43));
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    cyc(3);
    check(id_valid, 1'b1, "id valid");
    check(agent_id, 1'b0, "agent id");
    // Locked issue on request line zero
    @(posedge i_clk);
    dev_locked <= 1'b1;
    pulse(DEV_PUSH);
    wait_issues(1, 12);
    check(8'(issues), 8'h01, "first issue");
    check(req0_seen, 1'b1, "line zero used");
    check(lock_act, 1'b1, "lock active");
    @(posedge i_clk);
    dev_locked <= 1'b0;
    // Priority request held; locked traffic still passes
    pulse(PA_PUSH);
    cyc(3);
    check(fsb.priority_bus_req_n, 1'b0, "priority low");
    pulse(DEV_PUSH);
    wait_issues(2, 12);
    check(8'(issues), 8'h02, "locked issue under priority");
    pulse(LOCK_END);
    pulse(DEV_PUSH);
    cyc(10);
    check(8'(issues), 8'h02, "blocked by priority");
    // Freed request goes out locked, so bus init below has a lock to clear
    @(posedge i_clk);
    dev_locked <= 1'b1;
    pulse(PA_DONE);
    cyc(3);
    check(fsb.priority_bus_req_n, 1'b1, "priority released");
    check(8'(pa_issues), 8'h01, "priority agent issued");
    wait_issues(3, 12);
    check(8'(issues), 8'h03, "issue after priority");
    check(lock_act, 1'b1, "lock after priority");
    @(posedge i_clk);
    dev_locked <= 1'b0;
    // Stall imposed by the priority agent
    pa_cannot <= 1'b1;
    cyc(4);
    check(fsb.block_next_req_n, 1'b0, "stall line");
    check(stall_seen, 1'b1, "processor stall seen");
    check(pa_stall, 1'b1, "priority stall seen");
    pulse(DEV_PUSH);
    pulse(DEV_PUSH);
    cyc(10);
    check(8'(issues), 8'h03, "no issue in stall");
    check(pend, 4'h2, "pending in stall");
    // Bus init while stalled keeps queues, then re-arbitrates
    pulse(PA_FATAL);
    cyc(5);
    check(bus_init_n_hits != 0, 1'b1, "bus init observed");
    check(lock_act, 1'b0, "lock clear");
    check(pend, 4'h2, "pending kept");
    check(in_order_queue, 4'h3, "queue kept");
    @(posedge i_clk);
    pa_cannot <= 1'b0;
    wait_issues(5, 24);
    check(8'(issues), 8'h05, "pending completed");
    check(in_order_queue, 4'h5, "queue grows");
    pulse(TXN_DONE);
    check(in_order_queue, 4'h4, "queue entry done");
    // Mid-run reset clears the sticky error and the captured ID
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    cyc(2);
    check(bus_init_n_err, 1'b0, "error cleared by reset");
    check(id_valid, 1'b0, "id cleared by reset");
    @(posedge i_clk);
    i_arst_n <= 1'b1;
    cyc(3);
    check(id_valid, 1'b1, "id valid again");
    // Fatal error with the bus init driver disabled stays off the line
    @(posedge i_clk);
    drive_en <= 1'b0;
    pulse(DEV_FATAL);
    check(fsb.bus_init_n, 1'b1, "bus init driver disabled");
    @(posedge i_clk);
    drive_en <= 1'b1;
    // Processor drives bus init; priority agent flags it
    pulse(DEV_FATAL);
    check(fsb.bus_init_n, 1'b0, "bus init driven");
    cyc(4);
    check(bus_init_n_err, 1'b1, "unobserved bus init");
    // Random monitor, probe and frequency values
    for (int k = 0; k < 16; k++) begin
      @(posedge i_clk);
      bp_status <= BP_STAT_W'($urandom);
      probe_ready <= 1'($urandom);
      probe_request <= 1'($urandom);
      dev_cannot <= 1'($urandom);
      freq_code <= FSEL_W'(k);
      expected_freq <= FSEL_W'(k) ^ FSEL_W'($urandom_range(0, 1));
      cyc(4);
      bpm_exp = bpm_expect(bp_status, probe_ready, probe_request);
      check(fsb.break_perf_mon_n, bpm_exp, "bpm");
      check(fsb.block_next_req_n, !dev_cannot, "processor stall line");
      check(pa_stall, dev_cannot, "stall seen by priority");
      check(probe_ready_n_seen, probe_ready, "probe ready");
      check(probe_request_n_seen, probe_request, "probe request");
      check(fsb.clock_freq_select, freq_code, "freq select");
      check(freq_mis, freq_code !== expected_freq, "freq mismatch");
    end
    conclude();
  end
endmodule : tb_front_bus_arbitration_control
